// File: hw/psab_bank.sv
`timescale 1ns/1ps
// Function
// RL1 - Attributes selected by sixteen-bit identifier.
// RL2 - Low half standard, high half vendor only.
// RL3 - Undefined standard identifiers are reserved, inert.
// RL4 - Attribute registers never narrower than specified.
// RL5 - Count bursts with failed CRC, sixteen bits.
// RL6 - Count good-CRC bursts with invalid protocol.
// RL7 - Count transmit requests dropped on full queue.
// RL8 - Count receive data dropped on full queue.
// RL9 - Count correctly decoded frames, thirty-two bits.
// RL10 - Convert decibel quality k to 2^(k/2).
// RL11 - Sum linear quality over sixteen frames.
// RL12 - Average updates with divider 2^n smoothing.
// RL13 - Get request returns the attribute's value.
// RL14 - Counters and accumulator clear on reset.
module psab_bank #(
  parameter logic [psab_pkg::SMOOTH_W-1:0] SMOOTHING_DIVIDER = psab_pkg::SMOOTH_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic crc_fail_burst,
  input wire logic bad_protocol_burst,
  input wire logic tx_drop,
  input wire logic rx_drop,
  input wire logic good_frame,
  input wire logic quality_valid,
  input wire logic [psab_pkg::DB_W-1:0] quality_db,
  input wire logic get_valid,
  input wire logic [psab_pkg::ID_W-1:0] get_id,
  output logic get_done,
  output logic [psab_pkg::VALUE_W-1:0] get_value,
  output psab_pkg::psab_get_status_type get_status
);

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  logic [psab_pkg::SHORT_CNT_NUM-1:0] short_event;
  logic [psab_pkg::SHORT_CNT_W-1:0] short_count [psab_pkg::SHORT_CNT_NUM];
  logic [psab_pkg::LONG_CNT_W-1:0] good_frame_total_count;
  logic [psab_pkg::SMOOTH_W-1:0] average_smoothing_divider;

  // Index order follows the identifier order 0x00a0 to 0x00a3.
  assign short_event = {rx_drop, tx_drop, bad_protocol_burst, crc_fail_burst}; // see RL5

  generate
    for (genvar i = 0; i < psab_pkg::SHORT_CNT_NUM; i++) begin : g_short
      psab_counter #(
        .WIDTH(psab_pkg::SHORT_CNT_W)
      ) u_cnt (
        .clk(clk),
        .srst(srst),
        .bump(short_event[i]), // see RL6
        .count(short_count[i]) // see RL7
      );
    end
  endgenerate

  psab_counter #(
    .WIDTH(psab_pkg::LONG_CNT_W)
  ) u_good_frames (
    .clk(clk),
    .srst(srst),
    .bump(good_frame), // see RL9
    .count(good_frame_total_count)
  );

  // ----------------------------------------------------------------
  // Quality averaging
  // ----------------------------------------------------------------
  psab_quality_if qif ();

  assign average_smoothing_divider = SMOOTHING_DIVIDER;
  assign qif.sample_valid = quality_valid;
  assign qif.sample_db = quality_db;
  assign qif.divider = average_smoothing_divider; // see RL12

  psab_quality u_quality (
    .clk(clk),
    .srst(srst),
    .q(qif.quality)
  );

  // ----------------------------------------------------------------
  // Get service
  // ----------------------------------------------------------------
  logic next_get_done;
  logic [psab_pkg::VALUE_W-1:0] next_get_value;
  psab_pkg::psab_get_status_type next_get_status;

  // Every attribute is zero-extended into the full answer word.
  always_comb begin
    next_get_done = get_valid;
    next_get_value = get_value;
    next_get_status = get_status;
    if (get_valid) begin
      next_get_value = '0;
      next_get_status = psab_pkg::PSAB_GET_OK;
      case (get_id) // see RL1
        psab_pkg::ID_CRC_ERROR_BURST: begin
          next_get_value = psab_pkg::VALUE_W'(short_count[0]); // see RL13
        end
        psab_pkg::ID_BAD_PROTOCOL_BURST: begin
          next_get_value = psab_pkg::VALUE_W'(short_count[1]);
        end
        psab_pkg::ID_TRANSMIT_DROP: begin
          next_get_value = psab_pkg::VALUE_W'(short_count[2]);
        end
        psab_pkg::ID_RECEIVE_DROP: begin
          next_get_value = psab_pkg::VALUE_W'(short_count[3]); // see RL8
        end
        psab_pkg::ID_GOOD_FRAME_TOTAL: begin
          next_get_value = good_frame_total_count; // see RL4
        end
        psab_pkg::ID_BLOCK_QUALITY: begin
          next_get_value = psab_pkg::VALUE_W'(qif.average);
        end
        psab_pkg::ID_SMOOTHING_DIVIDER: begin
          next_get_value = psab_pkg::VALUE_W'(average_smoothing_divider);
        end
        default: begin
          if (get_id >= psab_pkg::VENDOR_FIRST_ID) begin
            next_get_status = psab_pkg::PSAB_GET_VENDOR; // see RL2
          end else begin
            next_get_status = psab_pkg::PSAB_GET_RESERVED; // see RL3
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      get_done <= 1'b0;
      get_value <= '0;
      get_status <= psab_pkg::PSAB_GET_OK;
    end else begin
      get_done <= next_get_done;
      get_value <= next_get_value;
      get_status <= next_get_status;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  get_latency_a: assert property (@(posedge clk) disable iff (srst) // see RL13
    get_valid |=> get_done) else $error("Get answer not given one cycle after request.");
  get_idle_a: assert property (@(posedge clk) disable iff (srst)
    !get_valid |=> !get_done) else $error("Get answer without request.");
  crc_value_a: assert property (@(posedge clk) disable iff (srst) // see RL5
    get_valid && get_id == psab_pkg::ID_CRC_ERROR_BURST |=>
    get_value == psab_pkg::VALUE_W'($past(short_count[0])) && get_status == psab_pkg::PSAB_GET_OK)
    else $error("CRC error count read wrong.");
  crc_count_a: assert property (@(posedge clk) disable iff (srst) // see RL5
    crc_fail_burst ##1 get_valid && get_id == psab_pkg::ID_CRC_ERROR_BURST ##1 1'b1 |->
    get_value[psab_pkg::SHORT_CNT_W-1:0] == $past(short_count[0], 2) + 16'h0001)
    else $error("CRC error burst not counted once.");
  drop_value_a: assert property (@(posedge clk) disable iff (srst) // see RL7
    get_valid && get_id == psab_pkg::ID_TRANSMIT_DROP |=>
    get_value == psab_pkg::VALUE_W'($past(short_count[2]))) else $error("Transmit drop count read wrong.");
  total_value_a: assert property (@(posedge clk) disable iff (srst) // see RL9
    get_valid && get_id == psab_pkg::ID_GOOD_FRAME_TOTAL |=> get_value == $past(good_frame_total_count))
    else $error("Good frame total read wrong.");
  divider_value_a: assert property (@(posedge clk) disable iff (srst) // see RL12
    get_valid && get_id == psab_pkg::ID_SMOOTHING_DIVIDER |=> get_value == 32'(SMOOTHING_DIVIDER))
    else $error("Smoothing divider read wrong.");
  reserved_id_a: assert property (@(posedge clk) disable iff (srst) // see RL3
    get_valid && get_id <= psab_pkg::STD_LAST_ID && (get_id < psab_pkg::ID_CRC_ERROR_BURST ||
    get_id > psab_pkg::ID_SMOOTHING_DIVIDER) |=> get_status == psab_pkg::PSAB_GET_RESERVED && get_value == '0)
    else $error("Reserved identifier not refused.");
  vendor_id_a: assert property (@(posedge clk) disable iff (srst) // see RL2
    get_valid && get_id >= psab_pkg::VENDOR_FIRST_ID |=> get_status == psab_pkg::PSAB_GET_VENDOR)
    else $error("Vendor identifier not flagged.");

  get_crc_c: cover property (@(posedge clk) disable iff (srst)
    crc_fail_burst ##1 get_valid && get_id == psab_pkg::ID_CRC_ERROR_BURST);
  get_back_c: cover property (@(posedge clk) disable iff (srst) get_valid [*3]);
  get_vendor_c: cover property (@(posedge clk) disable iff (srst)
    get_valid && get_id >= psab_pkg::VENDOR_FIRST_ID);
  quality_c: cover property (@(posedge clk) disable iff (srst) quality_valid && qif.average != '0);

endmodule : psab_bank

// File: pkg/psab_pkg.sv
package psab_pkg;

  // ----------------------------------------------------------------
  // Identifier space
  // ----------------------------------------------------------------
  localparam int ID_W = 16;
  localparam logic [ID_W-1:0] STD_LAST_ID = 16'h7fff;
  localparam logic [ID_W-1:0] VENDOR_FIRST_ID = 16'h8000;

  // ----------------------------------------------------------------
  // Attribute identifiers
  // ----------------------------------------------------------------
  localparam logic [ID_W-1:0] ID_CRC_ERROR_BURST = 16'h00a0;
  localparam logic [ID_W-1:0] ID_BAD_PROTOCOL_BURST = 16'h00a1;
  localparam logic [ID_W-1:0] ID_TRANSMIT_DROP = 16'h00a2;
  localparam logic [ID_W-1:0] ID_RECEIVE_DROP = 16'h00a3;
  localparam logic [ID_W-1:0] ID_GOOD_FRAME_TOTAL = 16'h00a4;
  localparam logic [ID_W-1:0] ID_BLOCK_QUALITY = 16'h00a5;
  localparam logic [ID_W-1:0] ID_SMOOTHING_DIVIDER = 16'h00a8;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SHORT_CNT_W = 16;
  localparam int LONG_CNT_W = 32;
  localparam int QUAL_W = 16;
  localparam int SMOOTH_W = 8;
  localparam int DB_W = 3;
  localparam int LIN_W = 7;
  localparam int VALUE_W = 32;
  localparam int SHORT_CNT_NUM = 4;
  localparam int BLOCK_CNT_W = 4;
  localparam logic [BLOCK_CNT_W-1:0] BLOCK_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Reset values and defaults
  // ----------------------------------------------------------------
  localparam logic [LONG_CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [QUAL_W-1:0] QUAL_RESET = 16'h0000;
  localparam logic [SMOOTH_W-1:0] SMOOTH_DEFAULT = 8'h00;

  // Linear quality 2^(k/2) as unsigned fixed point with three fraction bits.
  localparam logic [LIN_W-1:0] LIN_TABLE [8] = '{7'h08, 7'h0b, 7'h10, 7'h17, 7'h20, 7'h2d, 7'h40, 7'h5a};

  typedef enum logic [1:0] {
    PSAB_GET_OK = 2'h0,
    PSAB_GET_RESERVED = 2'h1,
    PSAB_GET_VENDOR = 2'h3
  } psab_get_status_type;

endpackage : psab_pkg

// File: pkg/psab_quality_if.sv
`timescale 1ns/1ps
interface psab_quality_if;
  logic sample_valid;
  logic [psab_pkg::DB_W-1:0] sample_db;
  logic [psab_pkg::SMOOTH_W-1:0] divider;
  logic [psab_pkg::QUAL_W-1:0] average;

  modport bank (output sample_valid, output sample_db, output divider, input average);
  modport quality (input sample_valid, input sample_db, input divider, output average);
endinterface : psab_quality_if

// File: hw/psab_counter.sv
`timescale 1ns/1ps
module psab_counter #(
  parameter int WIDTH = psab_pkg::SHORT_CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic bump,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] next_count;

  // ----------------------------------------------------------------
  // Event counter, wraps at full scale
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (bump) begin
      next_count = count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= psab_pkg::CNT_RESET[WIDTH-1:0]; // see RL14
    end else begin
      count <= next_count;
    end
  end

  counter_step_a: assert property (@(posedge clk) disable iff (srst)
    bump |=> count == $past(count) + WIDTH'(1)) else $error("Counter missed an event.");
  counter_hold_a: assert property (@(posedge clk) disable iff (srst)
    !bump |=> $stable(count)) else $error("Counter moved without an event.");

endmodule : psab_counter

// File: hw/psab_quality.sv
`timescale 1ns/1ps
module psab_quality (
  input wire logic clk,
  input wire logic srst,
  psab_quality_if.quality q
);

  logic [psab_pkg::BLOCK_CNT_W-1:0] frame_idx;
  logic [psab_pkg::BLOCK_CNT_W-1:0] next_frame_idx;
  logic [psab_pkg::QUAL_W-1:0] block_sum;
  logic [psab_pkg::QUAL_W-1:0] next_block_sum;
  logic [psab_pkg::QUAL_W-1:0] average;
  logic [psab_pkg::QUAL_W-1:0] next_average;
  logic [psab_pkg::QUAL_W-1:0] full_sum;
  logic signed [psab_pkg::QUAL_W+1:0] diff;
  logic signed [psab_pkg::QUAL_W+1:0] step;

  // ----------------------------------------------------------------
  // Block sum over sixteen frames, then moving average of the sums
  // ----------------------------------------------------------------
  always_comb begin
    full_sum = block_sum + psab_pkg::QUAL_W'(psab_pkg::LIN_TABLE[q.sample_db]); // see RL10
    diff = $signed({2'b00, full_sum}) - $signed({2'b00, average});
    step = diff >>> q.divider; // see RL12
    next_frame_idx = frame_idx;
    next_block_sum = block_sum;
    next_average = average;
    if (q.sample_valid) begin
      next_frame_idx = frame_idx + psab_pkg::BLOCK_CNT_W'(1);
      next_block_sum = full_sum; // see RL11
      if (frame_idx == psab_pkg::BLOCK_LAST) begin
        next_block_sum = psab_pkg::QUAL_RESET;
        next_average = average + step[psab_pkg::QUAL_W-1:0]; // see RL12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frame_idx <= '0;
      block_sum <= psab_pkg::QUAL_RESET; // see RL14
      average <= psab_pkg::QUAL_RESET; // see RL14
    end else begin
      frame_idx <= next_frame_idx;
      block_sum <= next_block_sum;
      average <= next_average;
    end
  end

  assign q.average = average;

  avg_toward_sum_a: assert property (@(posedge clk) disable iff (srst) // see RL11
    q.sample_valid && frame_idx == psab_pkg::BLOCK_LAST && full_sum >= average |=>
    average >= $past(average) && average <= $past(full_sum))
    else $error("Average moved away from the block sum.");
  avg_hold_a: assert property (@(posedge clk) disable iff (srst) // see RL12
    !(q.sample_valid && frame_idx == psab_pkg::BLOCK_LAST) |=> $stable(average))
    else $error("Average moved outside a block end.");

endmodule : psab_quality

// File: verif/psab_mgmt_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Management entity that issues attribute get requests
// ----------------------------------------------------------------
module psab_mgmt_model (
  input wire logic clk,
  input wire logic get_done,
  output logic get_valid,
  output logic [psab_pkg::ID_W-1:0] get_id
);
  initial begin
    get_valid = 1'b0;
    get_id = 16'hffff;
  end

  // The identifier is inverted once released so a stale value is never reused.
  task automatic get(input logic [psab_pkg::ID_W-1:0] id, output logic done_seen);
    @(posedge clk);
    #1;
    get_valid = 1'b1;
    get_id = id;
    @(posedge clk);
    #1;
    done_seen = get_done;
    get_valid = 1'b0;
    get_id = ~id;
  endtask : get
endmodule : psab_mgmt_model

// File: verif/psab_bank_test.sv
`timescale 1ns/1ps
module psab_bank_test;
  localparam logic [7:0] DIV = 8'h02;
  logic clk;
  logic srst;
  logic [4:0] ev;
  logic quality_valid;
  logic [2:0] quality_db;
  logic get_valid;
  logic [15:0] get_id;
  logic get_done;
  logic [31:0] get_value;
  psab_pkg::psab_get_status_type get_status;
  int fail_count;
  int samples_checked;
  int cycles;

  psab_bank #(.SMOOTHING_DIVIDER(DIV)) i_dut (.clk(clk), .srst(srst), .crc_fail_burst(ev[0]),
    .bad_protocol_burst(ev[1]), .tx_drop(ev[2]), .rx_drop(ev[3]), .good_frame(ev[4]),
    .quality_valid(quality_valid), .quality_db(quality_db), .get_valid(get_valid), .get_id(get_id),
    .get_done(get_done), .get_value(get_value), .get_status(get_status));

  psab_mgmt_model i_mgmt (.clk(clk), .get_done(get_done), .get_valid(get_valid), .get_id(get_id));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checked %0d values, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic read_expect(input logic [15:0] id, input logic [31:0] value, input logic [1:0] status);
    logic done;
    i_mgmt.get(id, done);
    check({31'h0, done}, 32'h1);
    check(get_value, value);
    check({30'h0, get_status}, {30'h0, status});
    @(posedge clk);
    #1;
    check({31'h0, get_done}, 32'h0);
  endtask : read_expect

  task automatic do_reset();
    @(posedge clk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask : do_reset

  task automatic feed(input logic [2:0] k);
    @(posedge clk);
    #1;
    quality_valid = 1'b1;
    quality_db = k;
    @(posedge clk);
    #1;
    quality_valid = 1'b0;
    quality_db = ~k;
  endtask : feed

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_counters();
    int counts [5] = '{3, 5, 1, 7, 9};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      ev[i] = 1'b1;
      repeat (counts[i]) @(posedge clk);
      #1;
      ev[i] = 1'b0;
    end
    read_expect(16'h00a0, 32'd3, 2'h0);
    read_expect(16'h00a1, 32'd5, 2'h0);
    read_expect(16'h00a2, 32'd1, 2'h0);
    read_expect(16'h00a3, 32'd7, 2'h0);
    read_expect(16'h00a4, 32'd9, 2'h0);
    // A burst event one cycle ahead of the read must already be counted.
    @(posedge clk);
    #1;
    ev[0] = 1'b1;
    fork
      read_expect(16'h00a0, 32'd4, 2'h0);
      begin
        @(posedge clk);
        #1;
        ev[0] = 1'b0;
      end
    join
    $display("test_counters done");
  endtask : test_counters

  task automatic test_quality();
    for (int i = 0; i < 15; i++) begin
      feed(i[2:0]);
    end
    read_expect(16'h00a5, 32'd0, 2'h0);
    feed(3'h7);
    read_expect(16'h00a5, 32'd144, 2'h0);
    for (int i = 0; i < 16; i++) begin
      feed(3'h7);
    end
    read_expect(16'h00a5, 32'd468, 2'h0);
    $display("test_quality done");
  endtask : test_quality

  task automatic test_zero();
    for (int i = 0; i < 6; i++) begin
      read_expect(16'h00a0 + 16'(i), 32'h0, 2'h0);
    end
    read_expect(16'h00a8, {24'h0, DIV}, 2'h0);
    $display("test_zero done");
  endtask : test_zero

  task automatic test_ids();
    logic [15:0] rsv [4] = '{16'h0000, 16'h00a6, 16'h00a7, 16'h7fff};
    foreach (rsv[i]) begin
      read_expect(rsv[i], 32'h0, 2'h1);
    end
    read_expect(16'h8000, 32'h0, 2'h3);
    read_expect(16'hffff, 32'h0, 2'h3);
    $display("test_ids done");
  endtask : test_ids

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    srst = 1'b1;
    ev = 5'h00;
    quality_valid = 1'b0;
    quality_db = 3'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    test_counters();
    test_quality();
    do_reset();
    test_zero();
    test_ids();
    report_and_stop();
  end
endmodule : psab_bank_test
